/* rtl/mwt_pkg.sv */
// Purpose: Constants, register map and default wave for the microstep wave table.
// Assumes: One table per driver channel; one clock; registers by index on a plain port.
// Notes: The default quarter wave is built at elaboration, not read from a file.
//
// Contract
// - Only the first quadrant is stored; the rest of the period is derived.
// - A 10-bit microstep position counter indexes the full expanded wave.
// - Quadrant is 256 one-bit entries in eight writable 32-bit words.
// - Each advance changes the value by base slope plus entry bit.
// - Four segments each carry base slope -1, 0, 1 or 2.
// - Segments split at three programmable boundaries, each ending one below the next.
// - Every advance stores fresh current values for both coils.
// - Both coil values reload from start values when a step, up or down, lands the counter on zero.
// - Wave value at position zero comes from a programmable start field.
// - Second coil starts from its own value, the 90 degree entry.
// - Segment select resets to FFFF8056: boundaries 128, 255, 255, slopes 1,0,0,0.
// - Start word resets to 00F70000: first coil 0, second coil 247.
// - Each channel's table resets to a sine wave, overwritable by software.

package mwt_pkg;

    // Register indices on the register port
    localparam logic [3:0] ADDR_TABLE0 = 4'h0;
    localparam logic [3:0] ADDR_SEG_SEL = 4'h8;
    localparam logic [3:0] ADDR_START = 4'h9;
    localparam logic [3:0] ADDR_POSITION = 4'hA;
    localparam logic [3:0] ADDR_CURRENT = 4'hB;

    // Sizes
    localparam int TABLE_WORDS = 8;
    localparam int TABLE_BITS = 256;
    localparam int POS_W = 10;
    localparam int CUR_W = 9;

    // Segment select fields
    localparam int SLOPE_W = 2;
    localparam int SLOPE0_LSB = 0;
    localparam int BOUND1_LSB = 8;
    localparam int BOUND2_LSB = 16;
    localparam int BOUND3_LSB = 24;

    // Start value fields
    localparam int START_A_LSB = 0;
    localparam int START_B_LSB = 16;

    // Reset values
    localparam logic [31:0] SEG_SEL_RST = 32'hFFFF8056;
    localparam logic [31:0] START_RST = 32'h00F70000;

    // Fixed-point rotation by a quarter period over 256 steps, 24 fractional bits
    localparam longint ROT_COS_Q = 64'sd16776900;
    localparam longint ROT_SIN_Q = 64'sd102944;
    localparam longint ROT_ONE_Q = 64'sd16777216;
    localparam longint ROT_HALF_Q = 64'sd8388608;
    localparam longint SINE_AMPL = 64'sd247;
    localparam int DEFAULT_X1 = 128;

    // Greedy encoding keeps every entry legal for the default segment slopes
    function automatic logic [255:0] mwt_default_table();
        logic [255:0] bits;
        longint c;
        longint s;
        longint cn;
        longint t;
        longint f;
        longint base;
        bits = '0;
        c = ROT_ONE_Q;
        s = 64'sd0;
        f = 64'sd0;
        for (int k = 0; k < TABLE_BITS; k++) begin
            cn = (c * ROT_COS_Q - s * ROT_SIN_Q) >>> 24;
            s = (s * ROT_COS_Q + c * ROT_SIN_Q) >>> 24;
            c = cn;
            t = (SINE_AMPL * s + ROT_HALF_Q) >>> 24;
            base = (k < DEFAULT_X1) ? 64'sd1 : 64'sd0;
            if (t - f - base > 0) begin
                bits[k] = 1'b1;
                f = f + base + 64'sd1;
            end else begin
                f = f + base;
            end
        end
        return bits;
    endfunction : mwt_default_table

    localparam logic [255:0] TABLE_RST = mwt_default_table();

endpackage : mwt_pkg

/* rtl/mwt_slope_if.sv */
// Purpose: Carries table, segment settings and slope lookups between the wave modules.
// Assumes: Lane 0 serves the first coil, lane 1 the second.
// Notes: Purely combinational lookup; no storage here.
`timescale 1ns/1ps

interface mwt_slope_if;
    logic [255:0] table_bits;
    logic [31:0] seg_sel;
    logic [7:0] idx [2];
    logic signed [2:0] delta [2];

    modport top (output table_bits, output seg_sel, output idx, input delta);
    modport unit (input table_bits, input seg_sel, input idx, output delta);
endinterface : mwt_slope_if

/* rtl/mwt_slope.sv */
// Purpose: Per-entry step of the stored quadrant: segment slope plus entry bit.
// Assumes: Boundaries are ordered by software; for unordered ones the earlier test wins.
// Notes: Two lanes so both coils step in the same cycle.
`timescale 1ns/1ps

module mwt_slope (
    // Lookup
    mwt_slope_if.unit sl
);

    logic [7:0] bound1;
    logic [7:0] bound2;
    logic [7:0] bound3;

    assign bound1 = sl.seg_sel[mwt_pkg::BOUND1_LSB +: 8];
    assign bound2 = sl.seg_sel[mwt_pkg::BOUND2_LSB +: 8];
    assign bound3 = sl.seg_sel[mwt_pkg::BOUND3_LSB +: 8];

    for (genvar g = 0; g < 2; g++) begin : g_lane
        logic [1:0] seg;
        logic [1:0] code;
        always_comb begin
            if (sl.idx[g] < bound1) begin
                seg = 2'h0;
            end else if (sl.idx[g] < bound2) begin
                seg = 2'h1;
            end else if (sl.idx[g] < bound3) begin
                seg = 2'h2;
            end else begin
                seg = 2'h3;
            end
        end
        assign code = sl.seg_sel[mwt_pkg::SLOPE0_LSB + 2 * seg +: mwt_pkg::SLOPE_W];
        // Code minus one gives -1..+2, then the entry bit adds one more
        assign sl.delta[g] = $signed({1'b0, code}) - 3'sh1
            + $signed({2'b00, sl.table_bits[sl.idx[g]]});
    end

endmodule : mwt_slope

/* rtl/mwt_top.sv */
// Purpose: Microstep wave table of one driver channel: stores, expands and steps the wave.
// Assumes: i_step and i_dir come from logic on i_clk; no synchronisers needed.
// Notes: Register read data appears one cycle after the address.
`timescale 1ns/1ps

module mwt_top (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Microstep advance
    input wire logic i_step,
    input wire logic i_dir,
    // Register port
    input wire logic i_reg_wr,
    input wire logic [3:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    output logic [31:0] o_reg_rdata,
    // Wave outputs
    output logic [9:0] o_microstep_position_counter,
    output logic signed [8:0] o_coil_a_current_value,
    output logic signed [8:0] o_coil_b_current_value
);

    ////////////////////////////////////////////////////////////////////////////////

    wire logic [255:0] table_reg;
    logic [31:0] wave_segment_select_reg;
    logic [31:0] wave_start_values_reg;
    logic [9:0] pos_reg;
    logic [9:0] pos_next;
    logic signed [8:0] mag_a_reg;
    logic signed [8:0] mag_b_reg;
    logic signed [8:0] mag_a_next;
    logic signed [8:0] mag_b_next;
    logic signed [8:0] coil_a_current_value_next;
    logic signed [8:0] coil_b_current_value_next;
    logic [9:0] ref_a;
    logic [9:0] ref_b;
    logic [9:0] pos_b_next;
    logic signed [8:0] first_coil_start_value;
    logic signed [8:0] second_coil_start_value;
    logic [31:0] rdata_next;

    mwt_slope_if sl ();

    mwt_slope u_slope (
        .sl(sl.unit)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    for (genvar w = 0; w < mwt_pkg::TABLE_WORDS; w++) begin : g_word
        // Each word owns its flip-flops, so no variable is written by two processes
        logic [31:0] word_reg;
        always_ff @(posedge i_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                word_reg <= mwt_pkg::TABLE_RST[32 * w +: 32];
            end else if (i_reg_wr && i_reg_addr == mwt_pkg::ADDR_TABLE0 + 4'(w)) begin
                word_reg <= i_reg_wdata;
            end
        end
        assign table_reg[32 * w +: 32] = word_reg;
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wave_segment_select_reg <= mwt_pkg::SEG_SEL_RST;
        end else if (i_reg_wr && i_reg_addr == mwt_pkg::ADDR_SEG_SEL) begin
            wave_segment_select_reg <= i_reg_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wave_start_values_reg <= mwt_pkg::START_RST;
        end else if (i_reg_wr && i_reg_addr == mwt_pkg::ADDR_START) begin
            wave_start_values_reg <= i_reg_wdata;
        end
    end

    // Start bytes are unsigned magnitudes of the stored quadrant
    assign first_coil_start_value =
        $signed({1'b0, wave_start_values_reg[mwt_pkg::START_A_LSB +: 8]});
    assign second_coil_start_value =
        $signed({1'b0, wave_start_values_reg[mwt_pkg::START_B_LSB +: 8]});

    ////////////////////////////////////////////////////////////////////////////////
    // Expansion of the stored quadrant

    // Up steps use the step's start position, down steps its end position
    assign pos_next = i_dir ? pos_reg + 10'h001 : pos_reg - 10'h001;
    assign ref_a = i_dir ? pos_reg : pos_next;
    assign ref_b = ref_a + 10'h100;
    assign pos_b_next = pos_next + 10'h100;

    // Odd quadrants walk the stored entries backwards
    assign sl.idx[0] = ref_a[8] ? ~ref_a[7:0] : ref_a[7:0];
    assign sl.idx[1] = ref_b[8] ? ~ref_b[7:0] : ref_b[7:0];
    assign sl.table_bits = table_reg;
    assign sl.seg_sel = wave_segment_select_reg;

    always_comb begin
        if (pos_next == 10'h000) begin
            // Incremental coding drifts after a table edit; zero re-anchors it
            mag_a_next = first_coil_start_value;
            mag_b_next = second_coil_start_value;
        end else begin
            // Rising in even quadrants, falling in odd ones, reversed for down steps
            mag_a_next = (i_dir ^ ref_a[8]) ? mag_a_reg + 9'(sl.delta[0])
                                            : mag_a_reg - 9'(sl.delta[0]);
            mag_b_next = (i_dir ^ ref_b[8]) ? mag_b_reg + 9'(sl.delta[1])
                                            : mag_b_reg - 9'(sl.delta[1]);
        end
        coil_a_current_value_next = pos_next[9] ? -mag_a_next : mag_a_next;
        coil_b_current_value_next = pos_b_next[9] ? -mag_b_next : mag_b_next;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer state

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pos_reg <= 10'h000;
        end else if (i_step) begin
            pos_reg <= pos_next;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mag_a_reg <= $signed(9'(mwt_pkg::START_RST[mwt_pkg::START_A_LSB +: 8]));
            mag_b_reg <= $signed(9'(mwt_pkg::START_RST[mwt_pkg::START_B_LSB +: 8]));
        end else if (i_step) begin
            mag_a_reg <= mag_a_next;
            mag_b_reg <= mag_b_next;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_microstep_position_counter <= 10'h000;
            o_coil_a_current_value <= $signed(9'(mwt_pkg::START_RST[mwt_pkg::START_A_LSB +: 8]));
            o_coil_b_current_value <= $signed(9'(mwt_pkg::START_RST[mwt_pkg::START_B_LSB +: 8]));
        end else if (i_step) begin
            o_microstep_position_counter <= pos_next;
            o_coil_a_current_value <= coil_a_current_value_next;
            o_coil_b_current_value <= coil_b_current_value_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read back

    always_comb begin
        rdata_next = 32'h00000000;
        if (i_reg_addr < mwt_pkg::ADDR_SEG_SEL) begin
            rdata_next = table_reg[32 * i_reg_addr[2:0] +: 32];
        end else if (i_reg_addr == mwt_pkg::ADDR_SEG_SEL) begin
            rdata_next = wave_segment_select_reg;
        end else if (i_reg_addr == mwt_pkg::ADDR_START) begin
            rdata_next = wave_start_values_reg;
        end else if (i_reg_addr == mwt_pkg::ADDR_POSITION) begin
            rdata_next = {22'h000000, pos_reg};
        end else if (i_reg_addr == mwt_pkg::ADDR_CURRENT) begin
            rdata_next = {7'h00, o_coil_b_current_value, 7'h00, o_coil_a_current_value};
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_reg_rdata <= 32'h00000000;
        end else begin
            o_reg_rdata <= rdata_next;
        end
    end

endmodule : mwt_top

/* tb/mwt_properties.sv */
// Purpose: Concurrent checks on the wave table ports.
// Assumes: Start values are zero-extended bytes; shadows track register writes.
// Notes: Start and select reads are judged only without a write, position reads only when no step lands.
`timescale 1ns/1ps

module mwt_properties (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Stimulus seen
    input wire logic i_step,
    input wire logic i_dir,
    input wire logic i_reg_wr,
    input wire logic [3:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    // Outputs watched
    input wire logic [31:0] o_reg_rdata,
    input wire logic [9:0] o_microstep_position_counter,
    input wire logic signed [8:0] o_coil_a_current_value,
    input wire logic signed [8:0] o_coil_b_current_value
);
    wire logic [9:0] pos = o_microstep_position_counter;
    wire logic [8:0] ca = o_coil_a_current_value;
    wire logic [8:0] cb = o_coil_b_current_value;
    logic [31:0] start_reg;
    logic [31:0] sel_reg;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            start_reg <= mwt_pkg::START_RST;
            sel_reg <= mwt_pkg::SEG_SEL_RST;
        end else if (i_reg_wr) begin
            if (i_reg_addr == mwt_pkg::ADDR_START) start_reg <= i_reg_wdata;
            if (i_reg_addr == mwt_pkg::ADDR_SEG_SEL) sel_reg <= i_reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb_main @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    sequence s_up; i_step && i_dir; endsequence
    sequence s_down; i_step && !i_dir; endsequence
    // Landing on zero from either side
    sequence s_to_zero; i_step && (i_dir ? pos == 10'h3FF : pos == 10'h001); endsequence

    pos_up_a: assert property (s_up |=> pos == $past(pos) + 10'h001)
        else $error("position did not advance");
    pos_down_a: assert property (s_down |=> pos == $past(pos) - 10'h001)
        else $error("position did not retreat");
    idle_hold_a: assert property (!i_step |=> $stable(pos) && $stable(ca) && $stable(cb))
        else $error("outputs moved without a step");
    reload_a_a: assert property (s_to_zero |=> ca == {1'b0, $past(start_reg[7:0])})
        else $error("coil a not reloaded at zero");
    reload_b_a: assert property (s_to_zero |=> cb == {1'b0, $past(start_reg[23:16])})
        else $error("coil b not reloaded at zero");
    unmapped_zero_a: assert property (i_reg_addr >= 4'hC |=> o_reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    start_read_a: assert property (i_reg_addr == 4'h9 && !i_reg_wr |=> o_reg_rdata == start_reg)
        else $error("start readback wrong");
    sel_read_a: assert property (i_reg_addr == 4'h8 && !i_reg_wr |=> o_reg_rdata == sel_reg)
        else $error("select readback wrong");
    pos_read_a: assert property (i_reg_addr == 4'hA && !i_step |=> o_reg_rdata == {22'h0, pos})
        else $error("position readback wrong");
endmodule : mwt_properties

bind mwt_top mwt_properties u_props (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_step(i_step), .i_dir(i_dir),
    .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_microstep_position_counter(o_microstep_position_counter),
    .o_coil_a_current_value(o_coil_a_current_value),
    .o_coil_b_current_value(o_coil_b_current_value)
);

/* tb/testbench.sv */
// Purpose: Directed tests of the microstep wave table.
// Assumes: Inputs change at the falling edge; one step per task call.
// Notes: Custom wave is checked against a model built here from the slope rules.
`timescale 1ns/1ps

module testbench;
    logic i_clk, i_rst_b, i_step, i_dir, i_reg_wr;
    logic [3:0] i_reg_addr;
    logic [31:0] i_reg_wdata, o_reg_rdata;
    logic [9:0] o_pos;
    logic signed [8:0] o_a, o_b;
    logic signed [8:0] wa [1024];
    logic signed [8:0] wb [1024];
    int fx [257];
    int miscompares = 0;
    int compares = 0;

    mwt_top uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_step(i_step), .i_dir(i_dir),
        .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata), .o_microstep_position_counter(o_pos),
        .o_coil_a_current_value(o_a), .o_coil_b_current_value(o_b));

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic step(input logic d);
        @(negedge i_clk);
        i_step = 1'b1;
        i_dir = d;
        @(negedge i_clk);
        i_step = 1'b0;
    endtask : step

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(negedge i_clk);
        i_reg_wr = 1'b1;
        i_reg_addr = a;
        i_reg_wdata = d;
        @(negedge i_clk);
        i_reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(negedge i_clk);
        i_reg_addr = a;
        @(negedge i_clk);
        chk(o_reg_rdata, exp);
    endtask : rd

    task automatic t_reset();
        i_rst_b = 1'b0;
        repeat (5) @(negedge i_clk);
        i_rst_b = 1'b1;
        chk(32'(o_pos), 32'h0);
        chk(32'(o_a), 32'h0);
        chk(32'(o_b), 32'h000000F7);
        rd(mwt_pkg::ADDR_SEG_SEL, 32'hFFFF8056);
        rd(mwt_pkg::ADDR_START, 32'h00F70000);
        $display("test reset done");
    endtask : t_reset

    // A full up period; symmetry is judged on the recorded wave
    task automatic t_default();
        for (int i = 0; i < 1024; i++) begin
            wa[i] = o_a;
            wb[i] = o_b;
            step(1'b1);
        end
        chk(32'(o_pos), 32'h0);
        chk(32'(wa[256]), 32'h000000F7);
        // Default quadrant rebuilt from the reset table bits and default slopes
        fx[0] = 0;
        for (int k = 0; k < 256; k++) begin
            fx[k + 1] = fx[k] + ((k < 128) ? 1 : 0) + int'(mwt_pkg::TABLE_RST[k]);
        end
        for (int i = 0; i <= 256; i++) chk(32'(wa[i]), 32'(fx[i]));
        for (int i = 0; i < 256; i++) begin
            chk(32'(wa[256 + i]), 32'(wa[(256 - i) % 1024]));
            chk(32'(wa[512 + i]), 32'(-wa[i]));
            chk(32'(wa[768 + i]), 32'(-wa[256 + i]));
        end
        for (int p = 0; p < 1024; p++) chk(32'(wb[p]), 32'(wa[(p + 256) % 1024]));
        $display("test default wave done");
    endtask : t_default

    // Slopes -1,0,1,2 over boundaries 64,128,192; entries 0 and 255 set
    task automatic t_custom();
        wr(mwt_pkg::ADDR_TABLE0, 32'h00000001);
        for (int w = 1; w < 7; w++) wr(4'(w), 32'h0);
        wr(4'h7, 32'h80000000);
        wr(mwt_pkg::ADDR_SEG_SEL, 32'hC08040E4);
        wr(mwt_pkg::ADDR_START, 32'h00E60064);
        fx[0] = 100;
        for (int k = 0; k < 256; k++) begin
            fx[k + 1] = fx[k] + ((k < 64) ? -1 : (k < 128) ? 0 : (k < 192) ? 1 : 2)
                + ((k == 0 || k == 255) ? 1 : 0);
        end
        step(1'b0);
        step(1'b1);
        chk(32'(o_a), 32'(fx[0]));
        chk(32'(o_b), 32'(fx[256]));
        for (int k = 1; k < 256; k++) begin
            step(1'b1);
            chk(32'(o_a), 32'(fx[k]));
            chk(32'(o_b), 32'(fx[256 - k]));
        end
        for (int k = 254; k >= 0; k--) begin
            step(1'b0);
            chk(32'(o_a), 32'(fx[k]));
        end
        $display("test custom wave done");
    endtask : t_custom

    task automatic t_regs();
        rd(mwt_pkg::ADDR_SEG_SEL, 32'hC08040E4);
        rd(mwt_pkg::ADDR_START, 32'h00E60064);
        rd(4'hC, 32'h0);
        rd(mwt_pkg::ADDR_TABLE0, 32'h00000001);
        rd(4'h7, 32'h80000000);
        wr(mwt_pkg::ADDR_POSITION, 32'hFFFFFFFF);
        rd(mwt_pkg::ADDR_POSITION, 32'h0);
        rd(mwt_pkg::ADDR_CURRENT, 32'h00E60064);
        $display("test registers done");
    endtask : t_regs

    task automatic finish_test();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    // Tests need about 5200 cycles; the limit allows roughly four times that
    initial begin
        #100000;
        miscompares++;
        finish_test();
    end

    initial begin
        {i_rst_b, i_step, i_dir, i_reg_wr, i_reg_addr, i_reg_wdata} = '0;
        t_reset();
        t_default();
        t_custom();
        t_regs();
        t_reset();
        t_default();
        finish_test();
    end
endmodule : testbench
